// file: rtl/tmw_timer.v
/*
 8-bit timer/counter with waveform output, registers over axi4-lite.
 holds mode control, counter, compare value, compare and wrap state,
 and the waveform pin logic.
 assumes clk is the prescaler source clock and inputs are synchronous.
*/
`timescale 1ns/1ns
`include "tmw_defs.vh"
module tmw_timer (
   input wire clk,
   input wire rst,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire pin_dir_out,
   input wire port_data,
   output wire wave_out_pin,
   output wire wave_out_oe_n,
   output wire match_event,
   output wire wrap_event
);
   // control register fields
   reg [7:0] timer_mode_control;
   reg [7:0] count_value;
   reg [7:0] match_value;
   reg [7:0] match_buf;
   reg count_down;
   reg block_match;
   reg wave_level;
   reg wrap_flag;
   reg match_flag;
   reg match_pulse;
   reg wrap_pulse;
   reg [7:0] next_count;
   reg next_down;
   reg next_wave;
   reg [7:0] rd_data;
   reg rd_ok;
   reg wr_ok;
   wire wr_en;
   wire [3:0] wr_addr;
   wire [7:0] wr_data;
   wire rd_en;
   wire [3:0] rd_addr;
   wire tick;
   wire [1:0] waveform_mode_sel;
   wire [1:0] output_action_sel;
   wire [2:0] prescale_sel;
   wire legacy_match_clear_bit;
   wire legacy_modulation_bit;
   wire is_pwm;
   wire [7:0] top_value;
   wire at_top;
   wire raw_match;
   wire do_match;
   wire wr_ctrl;
   wire wr_count;
   wire wr_match;
   wire wr_flags;
   wire force_match_strobe;
   wire top_special;

   // mode decode from the split field
   assign legacy_match_clear_bit = timer_mode_control[`TMW_BIT_MODE_HI];
   assign legacy_modulation_bit = timer_mode_control[`TMW_BIT_MODE_LO];
   assign waveform_mode_sel = {legacy_match_clear_bit, legacy_modulation_bit};
   assign output_action_sel = timer_mode_control[`TMW_BIT_ACT_HI:`TMW_BIT_ACT_LO];
   assign prescale_sel = timer_mode_control[`TMW_PS_HI:0];
   assign is_pwm = legacy_modulation_bit; // modes 1 and 3 are the pwm modes

   // top value per mode
   assign top_value = (waveform_mode_sel == `TMW_MODE_CTC) ? match_value : `TMW_MAX;
   assign at_top = (count_value == top_value);

   // bus decode
   assign wr_ctrl = wr_en && (wr_addr == `TMW_ADDR_CTRL);
   assign wr_count = wr_en && (wr_addr == `TMW_ADDR_COUNT);
   assign wr_match = wr_en && (wr_addr == `TMW_ADDR_MATCH);
   assign wr_flags = wr_en && (wr_addr == `TMW_ADDR_FLAGS);
   // force only acts outside pwm modes
   assign force_match_strobe = wr_ctrl && wr_data[`TMW_BIT_FORCE] && !wr_data[`TMW_BIT_MODE_LO];

   // compare on every tick unless the counter was just written
   assign raw_match = (count_value == match_value);
   assign do_match = tick && raw_match && !block_match;
   // compare equal to top with upper action bit: act at top instead
   assign top_special = is_pwm && output_action_sel[1] && (match_value == `TMW_MAX);

   tmw_prescaler #(
      .DIV_W(10)
   ) u_prescaler (
      .clk(clk),
      .rst(rst),
      .prescale_sel(prescale_sel),
      .tick(tick)
   );

   tmw_axil_slave u_bus (
      .clk(clk),
      .rst(rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok),
      .wr_ok(wr_ok)
   );

   // next count and direction per mode
   always @* begin
      next_count = count_value;
      next_down = count_down;
      case (waveform_mode_sel)
         `TMW_MODE_PCPWM: begin
            // dual slope, max and bottom each held one tick
            if (!count_down) begin
               if (count_value == `TMW_MAX) begin
                  next_down = 1'b1;
                  next_count = count_value - 8'h01;
               end else
                  next_count = count_value + 8'h01;
            end else begin
               if (count_value == `TMW_BOTTOM) begin
                  next_down = 1'b0;
                  next_count = count_value + 8'h01;
               end else
                  next_count = count_value - 8'h01;
            end
         end
         `TMW_MODE_CTC: begin
            next_down = 1'b0;
            // force strobe does not clear the timer, only a real match does
            next_count = at_top ? `TMW_BOTTOM : count_value + 8'h01;
         end
         default: begin
            next_down = 1'b0;
            next_count = count_value + 8'h01; // wraps at max naturally
         end
      endcase
   end

   // next waveform level from match, top and force events
   always @* begin
      next_wave = wave_level;
      if (!is_pwm) begin
         if (do_match || force_match_strobe) begin
            case (output_action_sel)
               `TMW_ACT_TOGGLE: next_wave = !wave_level;
               `TMW_ACT_CLEAR: next_wave = 1'b0;
               `TMW_ACT_SET: next_wave = 1'b1;
               default: next_wave = wave_level;
            endcase
         end
      end else if (waveform_mode_sel == `TMW_MODE_FAST) begin
         // clear or set on match, opposite at top
         if (tick && count_value == `TMW_MAX && output_action_sel[1])
            next_wave = !output_action_sel[0];
         else if (do_match && output_action_sel[1] && !top_special)
            next_wave = output_action_sel[0];
      end else begin
         // phase correct: up match gives act[0], down the inverse; bottom counts as up, so compare zero holds act[0] (low when clearing)
         if (tick && output_action_sel[1]) begin
            if (top_special && count_value == `TMW_MAX)
               next_wave = !output_action_sel[0];
            else if (do_match && !top_special)
               next_wave = (count_down && count_value != `TMW_BOTTOM) ? !output_action_sel[0] : output_action_sel[0];
         end
      end
   end

   // counter, direction, match blocking and compare buffering
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         count_value <= `TMW_RST8;
         count_down <= 1'b0;
         block_match <= 1'b0;
         match_value <= `TMW_RST8;
         match_buf <= `TMW_RST8;
      end else begin
         if (wr_count) begin
            count_value <= wr_data;
            block_match <= 1'b1;
         end else if (tick) begin
            count_value <= next_count;
            count_down <= next_down;
            block_match <= 1'b0;
         end
         // buffered copy tracks software; live value loads per mode
         if (wr_match)
            match_buf <= wr_data;
         if (!is_pwm) begin
            if (wr_match)
               match_value <= wr_data;
            else
               match_value <= match_buf;
         end else if (tick && count_value == `TMW_MAX && !count_down)
            match_value <= match_buf; // load at top
      end
   end

   // control register; force bit never stored so it reads as zero
   always @(posedge clk or posedge rst) begin
      if (rst)
         timer_mode_control <= `TMW_RST8;
      else if (wr_ctrl)
         timer_mode_control <= {1'b0, wr_data[6:0]};
   end

   // waveform level, flags and event pulses; set wins over clear
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wave_level <= 1'b0;
         wrap_flag <= 1'b0;
         match_flag <= 1'b0;
         match_pulse <= 1'b0;
         wrap_pulse <= 1'b0;
      end else begin
         wave_level <= next_wave;
         // a forced match raises no flag
         match_pulse <= do_match;
         // wrap at max, or at bottom in phase correct
         if (waveform_mode_sel == `TMW_MODE_PCPWM)
            wrap_pulse <= tick && count_down && count_value == `TMW_BOTTOM;
         else
            wrap_pulse <= tick && !wr_count && count_value == `TMW_MAX;
         if (do_match)
            match_flag <= 1'b1;
         else if (wr_flags && wr_data[`TMW_FLAG_MATCH])
            match_flag <= 1'b0;
         if (wrap_pulse)
            wrap_flag <= 1'b1;
         else if (wr_flags && wr_data[`TMW_FLAG_WRAP])
            wrap_flag <= 1'b0;
      end
   end

   // pin: waveform replaces port data when any action bit set
   assign wave_out_pin = (output_action_sel != `TMW_ACT_OFF) ? wave_level : port_data;
   assign wave_out_oe_n = !pin_dir_out;
   assign match_event = match_pulse;
   assign wrap_event = wrap_pulse;

   // read mux and decode answers
   always @* begin
      rd_ok = 1'b1;
      case (rd_addr)
         `TMW_ADDR_CTRL: rd_data = timer_mode_control;
         `TMW_ADDR_COUNT: rd_data = count_value;
         `TMW_ADDR_MATCH: rd_data = match_buf;
         `TMW_ADDR_FLAGS: rd_data = {6'h0, match_flag, wrap_flag};
         default: begin
            rd_data = `TMW_RST8;
            rd_ok = 1'b0;
         end
      endcase
      case (wr_addr)
         `TMW_ADDR_CTRL, `TMW_ADDR_COUNT, `TMW_ADDR_MATCH, `TMW_ADDR_FLAGS: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end
endmodule

// file: rtl/tmw_defs.vh
/*
 timer constants: register offsets, control field positions, mode and
 output action codes, prescaler ratios.
 assumes inclusion by bare name from the design files.
*/
`ifndef TMW_DEFS_VH
`define TMW_DEFS_VH
// byte addresses on the register bus
`define TMW_ADDR_CTRL 4'h0
`define TMW_ADDR_COUNT 4'h4
`define TMW_ADDR_MATCH 4'h8
`define TMW_ADDR_FLAGS 4'hC
// control field positions
`define TMW_BIT_FORCE 7
`define TMW_BIT_MODE_LO 6
`define TMW_BIT_ACT_HI 5
`define TMW_BIT_ACT_LO 4
`define TMW_BIT_MODE_HI 3
`define TMW_PS_HI 2
// flags register bits
`define TMW_FLAG_WRAP 0
`define TMW_FLAG_MATCH 1
// mode codes {hi,lo}
`define TMW_MODE_NORMAL 2'h0
`define TMW_MODE_PCPWM 2'h1
`define TMW_MODE_CTC 2'h2
`define TMW_MODE_FAST 2'h3
// output action codes
`define TMW_ACT_OFF 2'h0
`define TMW_ACT_TOGGLE 2'h1
`define TMW_ACT_CLEAR 2'h2
`define TMW_ACT_SET 2'h3
// counter limits
`define TMW_BOTTOM 8'h00
`define TMW_MAX 8'hFF
// reset value of all registers
`define TMW_RST8 8'h00
// prescaler tap points (divide ratio minus one)
`define TMW_DIV8 10'h007
`define TMW_DIV32 10'h01F
`define TMW_DIV64 10'h03F
`define TMW_DIV128 10'h07F
`define TMW_DIV256 10'h0FF
`define TMW_DIV1024 10'h3FF
// axi responses
`define TMW_RESP_OKAY 2'h0
`define TMW_RESP_SLVERR 2'h2
`endif

// file: rtl/tmw_prescaler.v
/*
 prescaler: free-running divider producing a one-cycle tick enable
 for the selected ratio.
 assumes clk is the prescaler source clock.
*/
`timescale 1ns/1ns
`include "tmw_defs.vh"
module tmw_prescaler #(
   parameter DIV_W = 10
) (
   input wire clk,
   input wire rst,
   input wire [2:0] prescale_sel,
   output reg tick
);
   reg [DIV_W-1:0] div_count;
   reg [DIV_W-1:0] tap;
   // free-running count; all ratios share it so they stay phase related
   always @(posedge clk or posedge rst) begin
      if (rst)
         div_count <= {DIV_W{1'b0}};
      else
         div_count <= div_count + 1'b1;
   end
   // tick when low bits of the divider all ones
   always @* begin
      case (prescale_sel)
         3'h2: tap = `TMW_DIV8;
         3'h3: tap = `TMW_DIV32;
         3'h4: tap = `TMW_DIV64;
         3'h5: tap = `TMW_DIV128;
         3'h6: tap = `TMW_DIV256;
         3'h7: tap = `TMW_DIV1024;
         default: tap = {DIV_W{1'b0}};
      endcase
      case (prescale_sel)
         3'h0: tick = 1'b0;              // stopped
         3'h1: tick = 1'b1;              // undivided
         default: tick = ((div_count & tap) == tap);
      endcase
   end
endmodule

// file: rtl/tmw_axil_slave.v
/*
 axi4-lite slave: accepts one write and one read, presents a simple
 register strobe interface to the timer core.
 assumes single outstanding transaction per direction.
*/
`timescale 1ns/1ns
`include "tmw_defs.vh"
module tmw_axil_slave (
   input wire clk,
   input wire rst,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output wire wr_en,
   output wire [3:0] wr_addr,
   output wire [7:0] wr_data,
   output wire rd_en,
   output wire [3:0] rd_addr,
   input wire [7:0] rd_data,
   input wire rd_ok,
   input wire wr_ok
);
   reg aw_held;
   reg w_held;
   reg [3:0] aw_addr;
   reg [7:0] w_data;
   reg w_lane;
   wire aw_take;
   wire w_take;
   // address and data latch independently, in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   // write issues once both halves are present; byte lane 0 gates it
   assign wr_en = aw_held && w_held && w_lane;
   assign wr_addr = aw_addr;
   assign wr_data = w_data;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_en = s_axi_arvalid && s_axi_arready;
   assign rd_addr = s_axi_araddr;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= `TMW_RST8;
         w_lane <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TMW_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
         end
         if (aw_held && w_held) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `TMW_RESP_OKAY : `TMW_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // read data registered one cycle after the address is taken
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `TMW_RESP_OKAY;
      end else if (rd_en) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h0, rd_data};
         s_axi_rresp <= rd_ok ? `TMW_RESP_OKAY : `TMW_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule

// file: test/tmw_timer_chk.sv
/*
 checker for tmw_timer: bus answers, pin enable, event pulses.
 assumes binding to tmw_timer, one clock, reset async high.
*/
`timescale 1ns/1ns
module tmw_timer_chk (
   input logic clk,
   input logic rst,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic pin_dir_out,
   input logic wave_out_oe_n,
   input logic match_event,
   input logic wrap_event
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // enable is active low, so it is the direction bit inverted
   a_oe_dir_map: assert property (wave_out_oe_n == !pin_dir_out)
      else $error("pin enable does not follow direction");
   // bus answers come within the stated cycles
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read not answered in time");
   a_read_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data above the low byte");
   a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read answer not released");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write not answered in time");
   // a pending answer refuses new requests, or a write could be lost
   a_write_lock: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   a_wrap_pulse: assert property (wrap_event |=> !wrap_event)
      else $error("wrap pulse longer than one cycle");
   a_match_pulse: assert property (match_event |=> !match_event)
      else $error("match pulse longer than one cycle");
endmodule

bind tmw_timer tmw_timer_chk u_tmw_timer_chk (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .pin_dir_out, .wave_out_oe_n, .match_event, .wrap_event);

// file: test/test_tmw_timer.sv
/*
 bench for tmw_timer: force actions, prescaler, wrap spacing,
 match blocking after counter writes, pwm duty and reset.
 assumes rtl/ on the include path and the bound checker.
*/
`timescale 1ns/1ns
`include "tmw_defs.vh"
module test_tmw_timer;
   localparam logic [3:0] a_ctl = `TMW_ADDR_CTRL;
   localparam logic [3:0] a_cnt = `TMW_ADDR_COUNT;
   localparam logic [3:0] a_cmp = `TMW_ADDR_MATCH;
   localparam logic [3:0] a_flg = `TMW_ADDR_FLAGS;
   logic clk, rst, aw_v, w_v, b_r, ar_v, r_r, dir, pdat;
   logic aw_r, w_r, b_v, ar_r, r_v, pin, oen, mev, wev;
   logic [3:0] aw_a, ar_a, w_s;
   logic [31:0] w_d, r_d;
   logic [1:0] b_rs, r_rs;
   int failures, samples_checked, cyc, mc, t0, t1, h, m0;
   // force rows: control, port level, pin afterwards
   logic [9:0] frc [0:9] = '{{8'h10, 2'h1}, {8'h10, 2'h0}, {8'h30, 2'h1}, {8'h20, 2'h0}, {8'h38, 2'h1},
      {8'h28, 2'h0}, {8'h18, 2'h1}, {8'h68, 2'h1}, {8'h00, 2'h3}, {8'h00, 2'h0}};
   // pwm rows: control, compare, high cycles, period
   int pw [0:5][0:3] = '{'{8'h69, 8'h80, 129, 256}, '{8'h79, 8'h80, 127, 256}, '{8'h69, 8'hFF, 256, 256},
      '{8'h61, 8'hFF, 510, 510}, '{8'h61, 8'h00, 0, 510}, '{8'h71, 8'h80, 254, 510}};
   int md [0:2][0:1] = '{'{8'h01, 256}, '{8'h41, 510}, '{8'h49, 256}};
   int dv [0:7] = '{0, 1, 8, 32, 64, 128, 256, 1024};

   tmw_timer u_tmw_timer (.clk(clk), .rst(rst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
      .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
      .s_axi_bresp(b_rs), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
      .pin_dir_out(dir), .port_data(pdat), .wave_out_pin(pin), .wave_out_oe_n(oen), .match_event(mev),
      .wrap_event(wev));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // cycle count and hang guard, ceiling well above the under-20k cycle run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         failures++;
         give_verdict();
      end
   end
   // tally of match pulses, sampled mid-cycle
   always @(negedge clk)
      if (mev === 1'b1) mc++;

   task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_cnt(input string n, input int e, input int g);
      samples_checked++;
      if (g != e) begin
         failures++;
         $display("wrong value %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // bus write: address and data together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e = `TMW_RESP_OKAY);
      logic pa, pw_, ta, tw;
      @(posedge clk);
      aw_a <= a;
      w_d <= {24'h000000, d};
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      pa = 1'b1;
      pw_ = 1'b1;
      // no local limit: a hung bus must end at the cycle guard, not pass
      while (pa || pw_) begin
         @(negedge clk);
         ta = pa && aw_r;
         tw = pw_ && w_r;
         @(posedge clk);
         if (ta) aw_v <= 1'b0;
         if (tw) w_v <= 1'b0;
         pa = pa && !ta;
         pw_ = pw_ && !tw;
      end
      do begin
         @(negedge clk);
      end while (b_v !== 1'b1);
      chk_val("write response", e, b_rs);
      @(posedge clk);
      b_r <= 1'b0;
   endtask

   // bus read: compares response, and data when an okay response is expected
   task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e = `TMW_RESP_OKAY);
      logic t;
      @(posedge clk);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      do begin
         @(negedge clk);
         t = ar_r;
         @(posedge clk);
      end while (t !== 1'b1);
      ar_v <= 1'b0;
      do begin
         @(negedge clk);
      end while (r_v !== 1'b1);
      chk_val("read response", e, r_rs);
      if (e === `TMW_RESP_OKAY) chk_val("read data", {24'h000000, d}, r_d);
      @(posedge clk);
      r_r <= 1'b0;
   endtask

   // next match (m high) or wrap pulse, returns its cycle number
   task automatic wait_ev(input logic m, output int t);
      do begin
         @(negedge clk);
      end while ((m ? mev : wev) !== 1'b1);
      t = cyc;
   endtask

   initial begin
      rst = 1'b1;
      {aw_v, w_v, b_r, ar_v, r_r, pdat} = 6'h00;
      dir = 1'b1;
      aw_a = 4'h0;
      ar_a = 4'h0;
      w_d = 32'h00000000;
      w_s = 4'hF;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // forces with the timer stopped; the action field is set first
      wr(a_cnt, 8'h33);
      for (int i = 0; i < 10; i++) begin
         pdat <= frc[i][1];
         wr(a_ctl, frc[i][9:2]);
         wr(a_ctl, frc[i][9:2] | 8'h80);
         rd(a_ctl, frc[i][9:2]);
         @(negedge clk);
         chk_val("wave pin", {31'h0, frc[i][0]}, {31'h0, pin});
      end
      rd(a_cnt, 8'h33);
      chk_cnt("forced matches", 0, mc);
      wr(4'h6, 8'h55, `TMW_RESP_SLVERR);
      rd(4'h6, 8'h00, `TMW_RESP_SLVERR);
      // ctc with top 1: a match every second tick at each divide
      wr(a_cmp, 8'h01);
      for (int s = 1; s < 8; s++) begin
         wr(a_ctl, 8'h08 | 8'(s));
         wait_ev(1'b1, t0);
         wait_ev(1'b1, t1);
         chk_cnt("match interval", 2 * dv[s], t1 - t0);
      end
      wr(a_ctl, 8'h08);
      m0 = mc;
      repeat (3000) @(negedge clk);
      chk_cnt("matches while stopped", m0, mc);
      // both flags were raised while running; clearing one leaves the other
      rd(a_flg, 8'h03);
      wr(a_flg, 8'h01);
      rd(a_flg, 8'h02);
      // counter written onto the compare value hides that match only
      wr(a_cmp, 8'h40);
      for (int k = 0; k < 2; k++) begin
         wr(a_ctl, 8'h00);
         wr(a_cnt, 8'(8'h40 - 3 * k));
         m0 = mc;
         wr(a_ctl, 8'h01);
         repeat (30) @(negedge clk);
         chk_cnt("matches after count write", m0 + k, mc);
      end
      // wrap spacing: single ramp, or up and down in phase correct
      for (int k = 0; k < 3; k++) begin
         wr(a_ctl, 8'(md[k][0]));
         wait_ev(1'b0, t0);
         wait_ev(1'b0, t1);
         chk_cnt("wrap interval", md[k][1], t1 - t0);
      end
      // pin duty over one period once the buffered compare has loaded
      for (int k = 0; k < 6; k++) begin
         wr(a_cmp, 8'(pw[k][1]));
         wr(a_ctl, 8'(pw[k][0]));
         wait_ev(1'b0, t0);
         wait_ev(1'b0, t1);
         h = 0;
         repeat (pw[k][3]) begin
            @(negedge clk);
            if (pin === 1'b1) h++;
         end
         chk_cnt("pin high cycles", pw[k][2], h);
      end
      // reset while counting clears everything and hands the pin back
      @(posedge clk);
      rst <= 1'b1;
      pdat <= 1'b1;
      dir <= 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(a_ctl, 8'h00);
      rd(a_cnt, 8'h00);
      rd(a_cmp, 8'h00);
      rd(a_flg, 8'h00);
      @(negedge clk);
      chk_val("pin after reset", 32'h1, {31'h0, pin});
      chk_val("driver enable", 32'h1, {31'h0, oen});
      give_verdict();
   end
endmodule
